// ==== hdl/spz_pkg.sv ====
// Purpose: Shared constants and types for serial port zero control
// Assumes: Byte-wide special function register access
// Notes: Register offsets are special function register addresses
package spz_pkg;
	localparam logic [7:0] CTRL_ADDR = 8'h98;
	localparam logic [7:0] DATA_ADDR = 8'h99;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int BIT_MODE_HI = 7;
	localparam int BIT_MODE_LO = 6;
	localparam int BIT_MPROC = 5;
	localparam int BIT_RXEN = 4;
	localparam int BIT_TX9 = 3;
	localparam int BIT_RX9 = 2;
	localparam int BIT_TXDONE = 1;
	localparam int BIT_RXDONE = 0;
	localparam int M0_SLOW_CLKS = 12;
	localparam int M0_FAST_CLKS = 4;
	localparam int M2_SLOW_CLKS = 64;
	localparam int M2_FAST_CLKS = 32;
	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] MID_SAMPLE = 4'h7;
	localparam logic [3:0] M0_BITS = 4'h8;
	localparam logic [3:0] M1_BITS = 4'hA;
	localparam logic [3:0] M23_BITS = 4'hB;
	localparam int FIFO_DEPTH = 16;
	typedef enum logic [1:0] {
		SPZ_MODE_SYNC = 2'h0,
		SPZ_MODE_ASYNC8 = 2'h1,
		SPZ_MODE_ASYNC9_FIX = 2'h2,
		SPZ_MODE_ASYNC9_TMR = 2'h3
	} spz_mode_e;
	// Shifter states, Gray coded along idle, start, shift, stop
	typedef enum logic [1:0] {
		SPZ_IDLE = 2'h0,
		SPZ_START = 2'h1,
		SPZ_SHIFT = 2'h3,
		SPZ_STOP = 2'h2
	} spz_state_e;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} spz_sfr_s;
endpackage

// ==== hdl/spz_fifo.sv ====
// Purpose: Parameterised valid/ready FIFO for transmit data
// Assumes: Single clock
// Notes: Depth is a power of two
`timescale 1ns/100ps
module spz_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic push, pop;
	always_comb begin
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wp_r[AW-1:0]] <= in_data_i;
		end
	end
	assign in_ready_o = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
	assign out_valid_o = (wp_r != rp_r);
	assign out_data_o = mem_r[rp_r[AW-1:0]];
endmodule

// ==== hdl/spz_ctrl.sv ====
// Purpose: Serial port zero control, shifting and status flags
// Assumes: Timer baud tick is a one-cycle pulse at sixteen times the bit rate
// Notes: Transmit bytes queue in a FIFO; a full queue drops the write
`timescale 1ns/100ps
// Notes on behaviour
// [RL1] Two mode bits pick sync 8-bit, async 10-bit, or async 11-bit frames.
// [RL2] Mode 0 shifts every 12 clocks, or every 4 with multiprocessor bit set.
// [RL3] Modes 1 and 3 time bits from the external timer baud tick.
// [RL4] Mode 2 bit period is 64 clocks, or 32 with baud doubling.
// [RL5] View select turns the top control bit into a sticky framing-error flag.
// [RL6] Mode bit and framing flag are stored apart; view-mode writes keep mode.
// [RL7] Mode 1 with multiprocessor bit drops frames with bad stop bit.
// [RL8] Modes 2 and 3 with multiprocessor bit need ninth bit one to flag.
// [RL9] Receive enable gates reception; in mode 0 setting it starts one receive.
// [RL10] Modes 2 and 3 send the transmit ninth bit as the ninth data bit.
// [RL11] Ninth received bit, or stop bit in mode 1 without multiprocessor bit, goes to the ninth field.
// [RL12] Transmit done sets after the last frame bit, the stop bit in async modes; software clears it.
// [RL13] Receive done sets at frame end per mode; software clears it.
// [RL14] Enabled port raises an interrupt while either done flag is set.
// [RL15] Data address writes go to transmit, reads return the receive register.
// [RL16] Transmit data write starts one frame, LSB first, with start and stop outside mode 0.
// [RL17] Async receive starts on a falling edge and samples bits mid-period.
module spz_ctrl (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Special function register access
	input wire spz_pkg::spz_sfr_s sfr_i,
	output logic [7:0] sfr_rdata_o,
	// System controls
	input wire logic framing_error_view_select_i,
	input wire logic baud_double_select_i,
	input wire logic serial0_irq_enable_i,
	input wire logic timer_baud_tick_i,
	// Serial pins
	input wire logic rxd_i,
	output logic rxd_o,
	output logic rxd_oe_o,
	output logic txd_o,
	// Interrupt request
	output logic irq_o
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic rx_meta_r, rx_sync_r, rx_prev_r;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
			rx_prev_r <= 1'b1;
		end else begin
			rx_meta_r <= rxd_i;
			rx_sync_r <= rx_meta_r;
			rx_prev_r <= rx_sync_r;
		end
	end

	// ----------------------------------------
	// Control register state
	// ----------------------------------------
	logic mode_hi_r, mode_lo_r, mproc_r, rxen_r, tx9_r, rx9_r;
	logic txdone_r, rxdone_r, ferr_r;
	logic mode_hi_nxt, mode_lo_nxt, mproc_nxt, rxen_nxt, tx9_nxt, rx9_nxt;
	logic txdone_nxt, rxdone_nxt, ferr_nxt;
	logic ctrl_wr, data_wr;
	spz_pkg::spz_mode_e mode;
	logic set_txdone, set_rxdone, set_ferr, set_rx9, rx9_val, m0_rx_start;
	always_comb begin
		ctrl_wr = sfr_i.wr && (sfr_i.addr == spz_pkg::CTRL_ADDR);
		data_wr = sfr_i.wr && (sfr_i.addr == spz_pkg::DATA_ADDR);
		mode = spz_pkg::spz_mode_e'({mode_hi_r, mode_lo_r}); // RL1
		mode_hi_nxt = mode_hi_r;
		ferr_nxt = ferr_r;
		mode_lo_nxt = mode_lo_r;
		mproc_nxt = mproc_r;
		rxen_nxt = rxen_r;
		tx9_nxt = tx9_r;
		rx9_nxt = rx9_r;
		txdone_nxt = txdone_r;
		rxdone_nxt = rxdone_r;
		if (ctrl_wr) begin
			if (framing_error_view_select_i) begin
				ferr_nxt = sfr_i.wdata[spz_pkg::BIT_MODE_HI]; // RL6
			end else begin
				mode_hi_nxt = sfr_i.wdata[spz_pkg::BIT_MODE_HI]; // RL5
			end
			mode_lo_nxt = sfr_i.wdata[spz_pkg::BIT_MODE_LO];
			mproc_nxt = sfr_i.wdata[spz_pkg::BIT_MPROC];
			rxen_nxt = sfr_i.wdata[spz_pkg::BIT_RXEN];
			tx9_nxt = sfr_i.wdata[spz_pkg::BIT_TX9];
			rx9_nxt = sfr_i.wdata[spz_pkg::BIT_RX9];
			txdone_nxt = sfr_i.wdata[spz_pkg::BIT_TXDONE];
			rxdone_nxt = sfr_i.wdata[spz_pkg::BIT_RXDONE];
		end
		// Hardware set wins over a same-cycle software clear
		if (set_ferr) ferr_nxt = 1'b1; // RL5
		if (set_rx9) rx9_nxt = rx9_val; // RL11
		if (set_txdone) txdone_nxt = 1'b1; // RL12
		if (set_rxdone) rxdone_nxt = 1'b1; // RL13
		// Rising receive enable in mode 0 launches one reception
		m0_rx_start = ctrl_wr && !rxen_r && rxen_nxt && mode == spz_pkg::SPZ_MODE_SYNC; // RL9
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			{mode_hi_r, mode_lo_r, mproc_r, rxen_r, tx9_r, rx9_r, txdone_r, rxdone_r} <= spz_pkg::CTRL_RESET;
			ferr_r <= 1'b0;
		end else begin
			{mode_hi_r, mode_lo_r, mproc_r, rxen_r} <= {mode_hi_nxt, mode_lo_nxt, mproc_nxt, rxen_nxt};
			{tx9_r, rx9_r, txdone_r, rxdone_r} <= {tx9_nxt, rx9_nxt, txdone_nxt, rxdone_nxt};
			ferr_r <= ferr_nxt;
		end
	end

	// ----------------------------------------
	// Bit-rate enables
	// ----------------------------------------
	// Async modes run a 16x sample tick; mode 0 uses one tick per bit
	logic [6:0] div_r, div_nxt;
	logic tick;
	logic [6:0] div_len;
	always_comb begin
		unique case (mode)
			spz_pkg::SPZ_MODE_SYNC: div_len = mproc_r ? 7'(spz_pkg::M0_FAST_CLKS) : 7'(spz_pkg::M0_SLOW_CLKS); // RL2
			spz_pkg::SPZ_MODE_ASYNC9_FIX: div_len = baud_double_select_i ? 7'(spz_pkg::M2_FAST_CLKS / spz_pkg::OVERSAMPLE)
				: 7'(spz_pkg::M2_SLOW_CLKS / spz_pkg::OVERSAMPLE); // RL4
			default: div_len = 7'h01;
		endcase
		div_nxt = (div_r + 7'h01 >= div_len) ? 7'h00 : div_r + 7'h01;
		if (mode == spz_pkg::SPZ_MODE_ASYNC8 || mode == spz_pkg::SPZ_MODE_ASYNC9_TMR) begin
			tick = timer_baud_tick_i; // RL3
		end else begin
			tick = (div_r + 7'h01 >= div_len);
		end
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) div_r <= 7'h00;
		else div_r <= div_nxt;
	end

	// ----------------------------------------
	// Transmit path
	// ----------------------------------------
	logic fifo_valid, fifo_ready, fifo_pop;
	logic [7:0] fifo_data;
	spz_fifo #(.WIDTH(8), .DEPTH(spz_pkg::FIFO_DEPTH)) u_txq (
		.clk_i(core_clk_i),
		.rst_i(rst_i),
		.in_valid_i(data_wr), // RL15
		.in_ready_o(fifo_ready),
		.in_data_i(sfr_i.wdata),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_data)
	);
	spz_pkg::spz_state_e tx_st_r, tx_st_nxt;
	logic [10:0] tx_sh_r, tx_sh_nxt;
	logic [3:0] tx_cnt_r, tx_cnt_nxt, tx_sub_r, tx_sub_nxt, tx_len;
	logic txd_r, txd_nxt, bit_tick, rx_busy;
	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_sh_nxt = tx_sh_r;
		tx_cnt_nxt = tx_cnt_r;
		tx_sub_nxt = tx_sub_r;
		txd_nxt = txd_r;
		fifo_pop = 1'b0;
		set_txdone = 1'b0;
		tx_len = (mode == spz_pkg::SPZ_MODE_SYNC) ? spz_pkg::M0_BITS
			: (mode == spz_pkg::SPZ_MODE_ASYNC8) ? spz_pkg::M1_BITS : spz_pkg::M23_BITS; // RL1
		bit_tick = tick && (mode == spz_pkg::SPZ_MODE_SYNC || tx_sub_r == 4'hF);
		if (tick) tx_sub_nxt = tx_sub_r + 4'h1;
		unique case (tx_st_r)
			spz_pkg::SPZ_IDLE: begin
				txd_nxt = 1'b1;
				if (fifo_valid && !rx_busy) begin
					fifo_pop = 1'b1;
					tx_sub_nxt = 4'h0;
					tx_cnt_nxt = 4'h0;
					// Frame LSB first: start, data, ninth, stop
					if (mode == spz_pkg::SPZ_MODE_SYNC) tx_sh_nxt = {3'h7, fifo_data};
					else if (mode == spz_pkg::SPZ_MODE_ASYNC8) tx_sh_nxt = {2'h3, fifo_data, 1'b0}; // RL16
					else tx_sh_nxt = {1'b1, tx9_r, fifo_data, 1'b0}; // RL10
					tx_st_nxt = spz_pkg::SPZ_SHIFT;
				end
			end
			spz_pkg::SPZ_SHIFT: begin
				if (bit_tick) begin
					txd_nxt = tx_sh_r[0];
					tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
					tx_cnt_nxt = tx_cnt_r + 4'h1;
					// Last frame bit is out; the stop state raises the done flag one bit later
					if (tx_cnt_r == tx_len - 4'h1) begin
						tx_st_nxt = spz_pkg::SPZ_STOP;
					end
				end
			end
			spz_pkg::SPZ_STOP: begin
				if (bit_tick) begin
					set_txdone = 1'b1; // RL12
					txd_nxt = 1'b1;
					tx_st_nxt = spz_pkg::SPZ_IDLE;
				end
			end
			default: tx_st_nxt = spz_pkg::SPZ_IDLE;
		endcase
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_st_r <= spz_pkg::SPZ_IDLE;
			tx_sh_r <= 11'h7FF;
			tx_cnt_r <= 4'h0;
			tx_sub_r <= 4'h0;
			txd_r <= 1'b1;
		end else begin
			tx_st_r <= tx_st_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_sub_r <= tx_sub_nxt;
			txd_r <= txd_nxt;
		end
	end

	// ----------------------------------------
	// Receive path
	// ----------------------------------------
	spz_pkg::spz_state_e rx_st_r, rx_st_nxt;
	logic [9:0] rx_sh_r, rx_sh_nxt;
	logic [7:0] rx_buf_r, rx_buf_nxt;
	logic [3:0] rx_cnt_r, rx_cnt_nxt, rx_sub_r, rx_sub_nxt;
	logic rx_sample, rx_ok;
	always_comb begin
		rx_st_nxt = rx_st_r;
		rx_sh_nxt = rx_sh_r;
		rx_buf_nxt = rx_buf_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_sub_nxt = rx_sub_r;
		set_rxdone = 1'b0;
		set_ferr = 1'b0;
		set_rx9 = 1'b0;
		rx9_val = rx9_r;
		rx_ok = 1'b0;
		rx_busy = (rx_st_r != spz_pkg::SPZ_IDLE) && (mode == spz_pkg::SPZ_MODE_SYNC);
		if (tick) rx_sub_nxt = rx_sub_r + 4'h1;
		rx_sample = tick && (mode == spz_pkg::SPZ_MODE_SYNC || rx_sub_r == spz_pkg::MID_SAMPLE); // RL17
		unique case (rx_st_r)
			spz_pkg::SPZ_IDLE: begin
				rx_cnt_nxt = 4'h0;
				if (m0_rx_start && tx_st_r == spz_pkg::SPZ_IDLE) begin
					rx_st_nxt = spz_pkg::SPZ_SHIFT; // RL9
				end else if (rxen_r && mode != spz_pkg::SPZ_MODE_SYNC && rx_prev_r && !rx_sync_r) begin
					rx_sub_nxt = 4'h0;
					rx_st_nxt = spz_pkg::SPZ_START; // RL17
				end
			end
			spz_pkg::SPZ_START: begin
				// A glitch that is high at mid-start is ignored
				if (rx_sample) rx_st_nxt = rx_sync_r ? spz_pkg::SPZ_IDLE : spz_pkg::SPZ_SHIFT;
			end
			spz_pkg::SPZ_SHIFT: begin
				if (rx_sample) begin
					rx_sh_nxt = {rx_sync_r, rx_sh_r[9:1]};
					rx_cnt_nxt = rx_cnt_r + 4'h1;
					if (mode == spz_pkg::SPZ_MODE_SYNC && rx_cnt_r == spz_pkg::M0_BITS - 4'h1) begin
						rx_buf_nxt = {rx_sync_r, rx_sh_r[9:3]};
						set_rxdone = 1'b1; // RL13
						rx_st_nxt = spz_pkg::SPZ_IDLE;
					end else if (rx_cnt_r == spz_pkg::M0_BITS - 4'h1) begin
						rx_st_nxt = spz_pkg::SPZ_STOP;
					end
				end
			end
			spz_pkg::SPZ_STOP: begin
				// Last sample: stop bit in mode 1, ninth bit in modes 2 and 3
				if (rx_sample) begin
					rx_st_nxt = spz_pkg::SPZ_IDLE;
					if (mode == spz_pkg::SPZ_MODE_ASYNC8) begin
						set_ferr = !rx_sync_r; // RL5
						rx_ok = !(mproc_r && !rx_sync_r); // RL7
						rx_buf_nxt = rx_ok ? rx_sh_r[9:2] : rx_buf_r;
						set_rx9 = rx_ok && !mproc_r; // RL11
					end else begin
						rx_ok = !(mproc_r && !rx_sync_r); // RL8
						rx_buf_nxt = rx_ok ? rx_sh_r[9:2] : rx_buf_r;
						set_rx9 = rx_ok; // RL11
					end
					rx9_val = rx_sync_r;
					set_rxdone = rx_ok; // RL13
				end
			end
			default: rx_st_nxt = spz_pkg::SPZ_IDLE;
		endcase
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_st_r <= spz_pkg::SPZ_IDLE;
			rx_sh_r <= 10'h000;
			rx_buf_r <= 8'h00;
			rx_cnt_r <= 4'h0;
			rx_sub_r <= 4'h0;
		end else begin
			rx_st_r <= rx_st_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_buf_r <= rx_buf_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_sub_r <= rx_sub_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Mode 0: data on the bidirectional pin, shift clock on the transmit pin
	logic [7:0] rdata_nxt;
	logic rxd_nxt, rxd_oe_nxt, txo_nxt, irq_nxt;
	always_comb begin
		rdata_nxt = 8'h00;
		if (sfr_i.addr == spz_pkg::CTRL_ADDR) begin
			rdata_nxt = {framing_error_view_select_i ? ferr_r : mode_hi_r, mode_lo_r, mproc_r, rxen_r,
				tx9_r, rx9_r, txdone_r, rxdone_r}; // RL5
		end else if (sfr_i.addr == spz_pkg::DATA_ADDR) begin
			rdata_nxt = rx_buf_r; // RL15
		end
		rxd_oe_nxt = (mode == spz_pkg::SPZ_MODE_SYNC) && (tx_st_r != spz_pkg::SPZ_IDLE);
		rxd_nxt = txd_r;
		txo_nxt = (mode == spz_pkg::SPZ_MODE_SYNC) ? !(tick && (tx_st_r != spz_pkg::SPZ_IDLE || rx_busy)) : txd_r;
		irq_nxt = serial0_irq_enable_i && (txdone_nxt || rxdone_nxt); // RL14
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sfr_rdata_o <= 8'h00;
			rxd_o <= 1'b1;
			rxd_oe_o <= 1'b0;
			txd_o <= 1'b1;
			irq_o <= 1'b0;
		end else begin
			sfr_rdata_o <= rdata_nxt;
			rxd_o <= rxd_nxt;
			rxd_oe_o <= rxd_oe_nxt;
			txd_o <= txo_nxt;
			irq_o <= irq_nxt;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	txdone_sticky_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL12
		txdone_r && !ctrl_wr |=> txdone_r) else $error("transmit done dropped without write");
	rxdone_sticky_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL13
		rxdone_r && !ctrl_wr |=> rxdone_r) else $error("receive done dropped without write");
	irq_follow_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL14
		$past(serial0_irq_enable_i) && (txdone_r || rxdone_r) |-> irq_o) else $error("missing interrupt");
	mode_keep_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL6
		ctrl_wr && framing_error_view_select_i |=> $stable(mode_hi_r)) else $error("mode changed in view");
	rx_disable_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL9
		rx_st_r == spz_pkg::SPZ_IDLE && !rxen_r && !ctrl_wr |=> rx_st_r == spz_pkg::SPZ_IDLE)
		else $error("reception while disabled");
	m2_div_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL4
		mode == spz_pkg::SPZ_MODE_ASYNC9_FIX && !baud_double_select_i |-> div_len == 7'h04)
		else $error("mode 2 period wrong");
	m0_div_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL2
		mode == spz_pkg::SPZ_MODE_SYNC |-> div_len == (mproc_r ? 7'h04 : 7'h0C)) else $error("mode 0 period wrong");
	mp_filter_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RL8
		rx_st_r == spz_pkg::SPZ_STOP && mode[1] && mproc_r && !rx_sync_r |-> !set_rxdone)
		else $error("filtered frame flagged");
endmodule

// ==== verif/spz_remote.sv ====
// Purpose: Remote serial station facing serial port zero
// Assumes: Idle line is high; bit times are given in core clocks
// Notes: Behavioural; the bench calls its tasks at falling edges
`timescale 1ns/100ps
module spz_remote (
	// Clock
	input wire logic clk_i,
	// Serial lines
	input wire logic line_i,
	output logic line_o
);
	// ----------------------------------------
	// Frame tasks
	// ----------------------------------------
	initial begin
		line_o = 1'b1;
	end
	// Start, n bits LSB first, stop level, then one idle bit
	task automatic send(input logic [9:0] bits, input int n, input int per, input logic stop);
		int i;
		line_o = 1'b0;
		repeat (per) @(negedge clk_i);
		for (i = 0; i < n; i++) begin
			line_o = bits[i];
			repeat (per) @(negedge clk_i);
		end
		line_o = stop;
		repeat (per) @(negedge clk_i);
		line_o = 1'b1;
		repeat (per) @(negedge clk_i);
	endtask
	// Mid-bit sampling, so a wrong bit period corrupts the data
	task automatic take(input int n, input int per, output logic [9:0] bits, output logic ok);
		int i;
		bits = '0;
		for (i = 0; i < 20000 && line_i !== 1'b0; i++) @(negedge clk_i);
		repeat (per / 2) @(negedge clk_i);
		ok = (line_i === 1'b0);
		for (i = 0; i < n; i++) begin
			repeat (per) @(negedge clk_i);
			bits[i] = line_i;
		end
	endtask
endmodule

// ==== verif/serial_port_zero_control_bench.sv ====
// Purpose: Self-checking bench for serial port zero control
// Assumes: Timer tick every 4 clocks gives a 64-clock async bit
// Notes: Remote station model sends and takes frames
`timescale 1ns/100ps
module serial_port_zero_control_bench;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	spz_pkg::spz_sfr_s sfr_i = '0;
	logic [7:0] sfr_rdata_o;
	logic fe_view = 1'b0;
	logic dbl = 1'b0;
	logic irq_en = 1'b1;
	logic tick = 1'b0;
	logic [1:0] tick_cnt = 2'h0;
	logic rxd_o, rxd_oe_o, txd_o, irq_o, far_line, rxd_pin;
	logic [7:0] r;
	logic [9:0] bits;
	logic ok;
	logic sclk_prev = 1'b1;
	logic [7:0] m0_sh = 8'h00;
	int error_cnt = 0;
	int num_checks = 0;
	int i;
	int n;

	always #4 core_clk_i = ~core_clk_i;
	// Timer stand-in: one tick in four clocks
	always @(negedge core_clk_i) begin
		tick_cnt <= tick_cnt + 2'h1;
		tick <= (tick_cnt == 2'h3);
	end
	// Mode 0 drives the receive pin itself
	assign rxd_pin = rxd_oe_o ? rxd_o : far_line;
	// Mode 0 data is valid at the rising shift clock, LSB first
	always @(negedge core_clk_i) begin
		if (!sclk_prev && txd_o && rxd_oe_o) m0_sh <= {rxd_o, m0_sh[7:1]};
		sclk_prev <= txd_o;
	end

	spz_ctrl dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_i(sfr_i), .sfr_rdata_o(sfr_rdata_o),
		.framing_error_view_select_i(fe_view), .baud_double_select_i(dbl), .serial0_irq_enable_i(irq_en),
		.timer_baud_tick_i(tick), .rxd_i(rxd_pin), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o),
		.irq_o(irq_o));
	spz_remote far_u (.clk_i(core_clk_i), .line_i(txd_o), .line_o(far_line));

	// ----------------------------------------
	// Access and check tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge core_clk_i);
		sfr_i.wr = 1'b0;
		// One idle edge so the next call never re-raises the strobe at once
		@(negedge core_clk_i);
	endtask
	// Read data is registered, one cycle behind the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sfr_i.addr = a;
		@(negedge core_clk_i);
		d = sfr_rdata_o;
	endtask
	task automatic waitf(input logic [7:0] m);
		for (n = 0; n < 4000; n++) begin
			rd(spz_pkg::CTRL_ADDR, r);
			if ((r & m) != 8'h00) return;
		end
		error_cnt++;
		final_report();
	endtask
	task automatic irqchk(input logic v);
		repeat (2) @(negedge core_clk_i);
		chk({7'h0, irq_o}, {7'h0, v});
	endtask
	// Clocks between two mode 0 shift-clock pulses
	task automatic gap(output int c);
		for (n = 0; n < 500 && txd_o !== 1'b0; n++) @(negedge core_clk_i);
		c = 0;
		do begin
			@(negedge core_clk_i);
			c++;
		end while (txd_o !== 1'b0 && c < 100);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int c;
		repeat (3) @(negedge core_clk_i);
		rst_i = 1'b0;
		rd(spz_pkg::CTRL_ADDR, r);
		chk(r, spz_pkg::CTRL_RESET);
		rd(8'h42, r);
		chk(r, 8'h00);
		// Mode 2 transmit at both bit periods, both ninth-bit values
		for (i = 0; i < 2; i++) begin
			dbl = i[0];
			wr(spz_pkg::CTRL_ADDR, {4'h8, i[0], 3'h0});
			wr(spz_pkg::DATA_ADDR, 8'hA5 ^ i[7:0]);
			far_u.take(10, i ? 32 : 64, bits, ok);
			chk({7'h0, ok}, 8'h01);
			chk(bits[7:0], 8'hA5 ^ i[7:0]);
			chk({6'h0, bits[9:8]}, {6'h0, 1'b1, i[0]});
			waitf(8'h02);
			irqchk(1'b1);
			wr(spz_pkg::CTRL_ADDR, 8'h80);
			irqchk(1'b0);
		end
		// Mode 2 receive with address filtering
		dbl = 1'b0;
		wr(spz_pkg::CTRL_ADDR, 8'hB0);
		far_u.send(10'h03C, 9, 64, 1'b1);
		rd(spz_pkg::CTRL_ADDR, r);
		chk(r & 8'h01, 8'h00);
		far_u.send(10'h1C3, 9, 64, 1'b1);
		rd(spz_pkg::CTRL_ADDR, r);
		chk(r, 8'hB5);
		rd(spz_pkg::DATA_ADDR, r);
		chk(r, 8'hC3);
		irqchk(1'b1);
		irq_en = 1'b0;
		irqchk(1'b0);
		irq_en = 1'b1;
		// Mode 1: receiver off, then on
		wr(spz_pkg::CTRL_ADDR, 8'h40);
		far_u.send(10'h096, 8, 64, 1'b1);
		rd(spz_pkg::CTRL_ADDR, r);
		chk(r & 8'h01, 8'h00);
		wr(spz_pkg::CTRL_ADDR, 8'h50);
		far_u.send(10'h096, 8, 64, 1'b1);
		rd(spz_pkg::CTRL_ADDR, r);
		chk(r, 8'h55);
		rd(spz_pkg::DATA_ADDR, r);
		chk(r, 8'h96);
		// Bad stop bit seen through the framing-error view
		fe_view = 1'b1;
		wr(spz_pkg::CTRL_ADDR, 8'h70);
		far_u.send(10'h096, 8, 64, 1'b0);
		rd(spz_pkg::CTRL_ADDR, r);
		chk(r & 8'h81, 8'h80);
		wr(spz_pkg::CTRL_ADDR, 8'hF0);
		fe_view = 1'b0;
		rd(spz_pkg::CTRL_ADDR, r);
		chk(r, 8'h70);
		fe_view = 1'b1;
		wr(spz_pkg::CTRL_ADDR, 8'h70);
		rd(spz_pkg::CTRL_ADDR, r);
		chk(r & 8'h80, 8'h00);
		fe_view = 1'b0;
		// Mode 0 shift period, slow then fast
		for (i = 0; i < 2; i++) begin
			wr(spz_pkg::CTRL_ADDR, {2'h0, i[0], 5'h0});
			wr(spz_pkg::DATA_ADDR, i ? 8'h1E : 8'h0F);
			gap(c);
			chk(c[7:0], i ? 8'h04 : 8'h0C);
			waitf(8'h02);
			chk(m0_sh, i ? 8'h1E : 8'h0F);
		end
		// Mode 0 receive launched by the enable write; idle far line reads ones
		wr(spz_pkg::CTRL_ADDR, 8'h30);
		waitf(8'h01);
		rd(spz_pkg::DATA_ADDR, r);
		chk(r, 8'hFF);
		// Queue overrun: one byte shifting, 16 queued, the last dropped
		dbl = 1'b1;
		wr(spz_pkg::CTRL_ADDR, 8'h80);
		for (i = 0; i < 18; i++) wr(spz_pkg::DATA_ADDR, i[7:0]);
		for (i = 0; i < 17; i++) begin
			far_u.take(10, 32, bits, ok);
			chk({7'h0, ok}, 8'h01);
			chk(bits[7:0], i[7:0]);
		end
		c = 0;
		repeat (800) begin
			@(negedge core_clk_i);
			if (txd_o !== 1'b1) c++;
		end
		chk(c[7:0], 8'h00);
		final_report();
	end
endmodule
